// ===== include/pas_pkg.sv
// package for the main-loop activation sequencer
package pas_pkg;
   // ----------------------------------------------
   // register map
   // ----------------------------------------------
   localparam logic [3:0] PAS_OFF_CTRL   = 4'h0;
   localparam logic [3:0] PAS_OFF_MULT   = 4'h4;
   localparam logic [3:0] PAS_OFF_STATUS = 4'h8;
   localparam logic [3:0] PAS_OFF_BUILD  = 4'hC;
   // ctrl field positions
   localparam int PAS_CTRL_DET_LSB   = 0;
   localparam int PAS_CTRL_STBY_BIT  = 3;
   localparam int PAS_CTRL_OUTB_BIT  = 4;
   // reset values and field encodings
   localparam logic [2:0]  PAS_DET_RST  = 3'h0;
   localparam logic        PAS_STBY_RST = 1'b1;
   localparam logic        PAS_OUTB_RST = 1'b0;
   localparam logic [2:0]  PAS_MULT_RST = 3'h0;
   localparam logic [2:0]  PAS_DET_BOTH = 3'h3;
   localparam logic [2:0]  PAS_DET_NONE = 3'h0;
   localparam logic [2:0]  PAS_MULT_OFF = 3'h0;
   // build interval default: C*V/I with 100 uA, taken as 10 us here
   localparam int PAS_CLK_MHZ      = 200;
   localparam int PAS_BUILD_US     = 10;
   localparam int PAS_BUILD_CYC    = PAS_BUILD_US * PAS_CLK_MHZ;
   localparam logic [31:0] PAS_BUILD_RST = 32'(PAS_BUILD_CYC);

   typedef struct packed {
      logic [2:0] det;
      logic       stby;
      logic       outb;
   } pas_ctrl_t;

   typedef struct packed {
      logic hi_en;
      logic lo_en;
   } pas_pump_t;
endpackage : pas_pkg

// ===== rtl/pas_seq.sv
// main-loop activation sequencer with avalon register slave
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------
// Notes on behaviour
// R01 - power-on reset floats both main-loop pump outputs.
// R02 - host keeps pumps floating for the build interval C*V/100uA after power-up.
// R03 - a multiplier field of 000 turns the multiplier off, any other value keeps it alive.
// R04 - after re-enabling the multiplier the host waits the build interval again.
// R05 - with the main loop active the multiplier only maintains and cannot build.
// R06 - host loads all counters and setting bits before leaving standby.
// R07 - main loop activates once host writes the detector field or standby bit active; here only the standby bit activates it.
// R08 - external reference only when mode pin high and select bit 1, else crystal.
// R09 - output B drives the select bit when active and floats in standby.
// R10 - standby bit 0 means active, 1 means standby, whatever the mode pin.
// R11 - detector field 000 floats both pumps and 011 enables both.
// ----------------------------------------------
module pas_seq (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        mode_pin_i,
   output logic             high_current_pump_out_o,
   output logic             low_current_pump_out_o,
   output logic             mult_on_o,
   output logic             mult_build_o,
   output logic             ext_ref_mode_o,
   output logic             outb_o,
   output logic             outb_oe_o,
   output logic             loop_active_o
);
   import pas_pkg::*;

   // ----------------------------------------------
   // mode pin synchroniser
   // ----------------------------------------------
   logic       mode_s1;
   logic       mode_s2;
   logic       mode_s3;
   logic       mode_q;
   logic       mode_agree;
   logic       next_mode_q;
   assign mode_agree  = mode_s2 == mode_s3;
   assign next_mode_q = mode_agree ? mode_s3 : mode_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
         mode_s3 <= 1'b0;
      end else begin
         mode_s1 <= mode_pin_i;
         mode_s2 <= mode_s1;
         mode_s3 <= mode_s2;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= 1'b0;
      end else begin
         mode_q <= next_mode_q;
      end
   end

   // ----------------------------------------------
   // register storage
   // ----------------------------------------------
   pas_ctrl_t   ctrl;
   logic [2:0]  mult_field;
   logic [31:0] build_len;
   logic [31:0] build_cnt;
   logic        ack;

   // ----------------------------------------------
   // bus decode
   // ----------------------------------------------
   logic        req;
   logic        wr_fire;
   logic        rd_start;
   logic        sel_ctrl;
   logic        sel_mult;
   logic        sel_stat;
   logic        sel_bld;
   logic        wr_ctrl;
   logic        wr_mult;
   logic        wr_bld;
   assign req      = avs_read_i | avs_write_i;
   assign wr_fire  = avs_write_i & ack;
   assign rd_start = avs_read_i & ~ack;
   assign sel_ctrl = avs_address_i == PAS_OFF_CTRL;
   assign sel_mult = avs_address_i == PAS_OFF_MULT;
   assign sel_stat = avs_address_i == PAS_OFF_STATUS;
   assign sel_bld  = avs_address_i == PAS_OFF_BUILD;
   assign wr_ctrl  = wr_fire & sel_ctrl;
   assign wr_mult  = wr_fire & sel_mult;
   assign wr_bld   = wr_fire & sel_bld;
   // one wait cycle then answer
   assign avs_waitrequest_o = req & ~ack;

   // ----------------------------------------------
   // behaviour wires
   // ----------------------------------------------
   logic        mult_on;
   logic        building;
   logic        loop_active;
   logic        hi_en;
   logic        lo_en;
   assign mult_on     = mult_field != PAS_MULT_OFF;                   // R03
   assign building    = mult_on & (build_cnt != 32'h0);
   assign loop_active = ~ctrl.stby;                                   // R10 R07
   assign hi_en       = loop_active & ctrl.det[1];                    // R11
   assign lo_en       = loop_active & ctrl.det[0];                    // R11

   // ----------------------------------------------
   // read back
   // ----------------------------------------------
   logic [31:0] status;
   logic [31:0] ctrl_rd;
   logic [31:0] mult_rd;
   logic [31:0] rd_mux;
   assign status  = {26'h0, mode_q, building, mult_on, loop_active, lo_en, hi_en};
   assign ctrl_rd = {27'h0, ctrl.outb, ctrl.stby, ctrl.det};
   assign mult_rd = {29'h0, mult_field};
   assign rd_mux  = sel_ctrl ? ctrl_rd :
                    sel_mult ? mult_rd :
                    sel_stat ? status :
                    sel_bld  ? build_len : 32'h0;

   // ----------------------------------------------
   // next values
   // ----------------------------------------------
   pas_ctrl_t   wr_ctrl_val;
   pas_ctrl_t   next_ctrl;
   logic [2:0]  next_mult_field;
   logic [31:0] next_build_len;
   logic [31:0] next_build_cnt;
   logic        next_ack;
   logic [31:0] next_readdata;
   assign wr_ctrl_val = {avs_writedata_i[PAS_CTRL_DET_LSB +: 3],
                         avs_writedata_i[PAS_CTRL_STBY_BIT],
                         avs_writedata_i[PAS_CTRL_OUTB_BIT]};
   assign next_ctrl       = wr_ctrl ? wr_ctrl_val : ctrl;
   assign next_mult_field = wr_mult ? avs_writedata_i[2:0] : mult_field;
   assign next_build_len  = wr_bld ? avs_writedata_i : build_len;
   // build timer restarts when multiplier is off; only runs while loop idle
   assign next_build_cnt  = !mult_on ? build_len :                    // R04
                            (building & ~loop_active) ? build_cnt - 32'h1 : // R05
                            build_cnt;
   assign next_ack        = req & ~ack;
   assign next_readdata   = rd_start ? rd_mux : avs_readdata_o;

   // ----------------------------------------------
   // registers
   // ----------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack <= 1'b0;
      end else begin
         ack <= next_ack;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= 32'h0;
      end else begin
         avs_readdata_o <= next_readdata;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl <= {PAS_DET_RST, PAS_STBY_RST, PAS_OUTB_RST};           // R01
      end else begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mult_field <= PAS_MULT_RST;
      end else begin
         mult_field <= next_mult_field;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         build_len <= PAS_BUILD_RST;
      end else begin
         build_len <= next_build_len;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         build_cnt <= PAS_BUILD_RST;
      end else begin
         build_cnt <= next_build_cnt;
      end
   end

   // ----------------------------------------------
   // outputs
   // ----------------------------------------------
   assign high_current_pump_out_o = hi_en;
   assign low_current_pump_out_o  = lo_en;
   assign mult_on_o      = mult_on;
   assign mult_build_o   = building & ~loop_active;                   // R05
   assign ext_ref_mode_o = mode_q & ctrl.outb;                        // R08
   assign outb_o         = ctrl.outb;                                 // R09
   assign outb_oe_o      = loop_active;                               // R09
   assign loop_active_o  = loop_active;
endmodule : pas_seq
`default_nettype wire

// ===== bench/pas_seq_checker.sv
// port assertions for the activation sequencer
`timescale 1ns/10ps
`default_nettype none
module pas_seq_checker (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        avs_write_i,
   input wire logic        avs_waitrequest_o,
   input wire logic [3:0]  avs_address_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic        high_current_pump_out_o,
   input wire logic        low_current_pump_out_o,
   input wire logic        mult_on_o,
   input wire logic        mult_build_o,
   input wire logic        ext_ref_mode_o,
   input wire logic        outb_o,
   input wire logic        outb_oe_o,
   input wire logic        loop_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire [1:0] pu = {high_current_pump_out_o, low_current_pump_out_o};
   wire       ok = avs_write_i & ~avs_waitrequest_o;
   wire       wc = ok & (avs_address_i == 4'h0);
   wire       wm = ok & (avs_address_i == 4'h4);
   a_reset_float: assert property ($rose(rst_n_i) |-> pu == 2'h0)
      else $error("pumps driven after reset");
   a_pump_active: assert property (pu != 2'h0 |-> loop_active_o)
      else $error("pump driven in standby");
   a_outb_drive: assert property (outb_oe_o == loop_active_o)
      else $error("output b enable wrong");
   a_ext_ref: assert property (ext_ref_mode_o |-> outb_o)
      else $error("external reference without select");
   a_build_standby: assert property (mult_build_o |-> mult_on_o && !loop_active_o)
      else $error("build while active");
   a_ctrl_active: assert property (wc |=> loop_active_o == !$past(avs_writedata_i[3]))
      else $error("standby bit not applied");
   a_pump_field: assert property (wc |=> pu == ($past(avs_writedata_i[3]) ? 2'h0 :
      $past(avs_writedata_i[1:0]))) else $error("pump field wrong");
   a_mult_field: assert property (wm |=> mult_on_o == ($past(avs_writedata_i[2:0]) != 3'h0))
      else $error("multiplier field wrong");
   a_outb_value: assert property (wc |=> outb_o == $past(avs_writedata_i[4]))
      else $error("output b value wrong");
endmodule : pas_seq_checker
bind pas_seq pas_seq_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_write_i(avs_write_i),
   .avs_waitrequest_o(avs_waitrequest_o), .avs_address_i(avs_address_i),
   .avs_writedata_i(avs_writedata_i), .high_current_pump_out_o(high_current_pump_out_o),
   .low_current_pump_out_o(low_current_pump_out_o), .mult_on_o(mult_on_o),
   .mult_build_o(mult_build_o), .ext_ref_mode_o(ext_ref_mode_o), .outb_o(outb_o),
   .outb_oe_o(outb_oe_o), .loop_active_o(loop_active_o));
`default_nettype wire

// ===== bench/pas_host.sv
// host model driving the sequencer registers
`timescale 1ns/10ps
`default_nettype none
module pas_host (
   input  wire logic        clk_i,
   input  wire logic        wait_i,
   input  wire logic [31:0] rdata_i,
   output logic             rd_o,
   output logic             wr_o,
   output logic [3:0]       addr_o,
   output logic [31:0]      wdata_o
);
   initial {rd_o, wr_o, addr_o, wdata_o} = '0;
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
      do @(posedge clk_i); while (wait_i);
      q = rdata_i;
      {wr_o, rd_o} <= 2'h0;
   endtask : xfer
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : settle
endmodule : pas_host
`default_nettype wire

// ===== bench/pas_seq_bench.sv
// self-checking bench for the activation sequencer
`timescale 1ns/10ps
`default_nettype none
module pas_seq_bench;
   import pas_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, mode_pin_i = 1'b0;
   logic [31:0] rdata, wdata, q;
   logic [3:0] addr;
   logic wr, rd, wt, hi, lo, mon, mbld, xref, outb, oe, act;
   integer seed = 32'h5289569f;
   int fails = 0, check_count = 0;
   pas_ctrl_t c;
   pas_seq u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wt), .mode_pin_i(mode_pin_i), .high_current_pump_out_o(hi),
      .low_current_pump_out_o(lo), .mult_on_o(mon), .mult_build_o(mbld),
      .ext_ref_mode_o(xref), .outb_o(outb), .outb_oe_o(oe), .loop_active_o(act));
   pas_host u_host (.clk_i(clk_i), .wait_i(wt), .rdata_i(rdata), .rd_o(rd), .wr_o(wr),
      .addr_o(addr), .wdata_o(wdata));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   function automatic logic [5:0] expo(input pas_ctrl_t v, input logic m);
      return {m & v.outb, !v.stby, v.outb, !v.stby, v.stby ? 2'h0 : v.det[1:0]};
   endfunction : expo
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   initial forever #2.5 clk_i = ~clk_i;
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      final_report;
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      chk({hi, lo, act, oe, mon}, 32'h0);
      u_host.xfer(1'b0, PAS_OFF_CTRL, 32'h0, q); chk(q, 32'h8);
      u_host.xfer(1'b0, 4'h2, 32'h0, q); chk(q, 32'h0);
      u_host.xfer(1'b0, PAS_OFF_BUILD, 32'h0, q); chk(q, PAS_BUILD_RST);
      u_host.xfer(1'b1, PAS_OFF_MULT, 32'h5, q);
      u_host.settle(1); chk({mon, mbld}, 32'h3);
      u_host.xfer(1'b0, PAS_OFF_MULT, 32'h0, q);
      chk(q, 32'h5);
      u_host.settle(2100); chk(mbld, 32'h0);
      u_host.xfer(1'b0, PAS_OFF_STATUS, 32'h0, q);
      chk(q, 32'h8);
      u_host.xfer(1'b1, PAS_OFF_BUILD, 32'h10, q);
      u_host.xfer(1'b0, PAS_OFF_BUILD, 32'h0, q);
      chk(q, 32'h10);
      $display("test power-up done");
      for (int i = 0; i < 40; i++) begin
         c = 5'($random(seed));
         mode_pin_i <= 1'($random(seed));
         if (i < 8) begin
            c.det = 3'(i);
            c.stby = 1'b0;
         end
         u_host.xfer(1'b1, PAS_OFF_CTRL, {27'h0, c.outb, c.stby, c.det}, q);
         u_host.settle(5);
         chk({xref, oe, outb, act, hi, lo}, expo(c, mode_pin_i));
      end
      $display("test control done");
      u_host.xfer(1'b1, PAS_OFF_MULT, 32'h0, q);
      u_host.settle(1); chk(mon, 32'h0);
      u_host.xfer(1'b1, PAS_OFF_CTRL, 32'h3, q);
      u_host.xfer(1'b1, PAS_OFF_MULT, 32'h1, q);
      u_host.settle(1);
      chk({mon, mbld, hi, lo}, 32'hB);
      u_host.xfer(1'b1, PAS_OFF_CTRL, 32'h8, q);
      u_host.settle(1);
      chk({mon, mbld}, 32'h3);
      $display("test multiplier done");
      final_report;
   end
endmodule : pas_seq_bench
`default_nettype wire
